// file: core/dmvc_consts.vh
// Constants for the debug monitor and vector catch control block.
`ifndef DMVC_CONSTS_VH
`define DMVC_CONSTS_VH
`define DMVC_ADDR_FSR        32'he000ed30
`define DMVC_ADDR_FSR_NS     32'he002ed30
`define DMVC_ADDR_EMC        32'he000edfc
`define DMVC_ADDR_EMC_NS     32'he002edfc
`define DMVC_SEL_NONE        3'h0
`define DMVC_SEL_FSR         3'h1
`define DMVC_SEL_FSR_NS      3'h2
`define DMVC_SEL_EMC         3'h3
`define DMVC_SEL_EMC_NS      3'h4
`define DMVC_BIT_SECURE_MONITOR_TARGET_STATUS        20
`define DMVC_BIT_SEMA        19
`define DMVC_BIT_STEP        18
`define DMVC_BIT_PEND        17
`define DMVC_BIT_MEN         16
`define DMVC_CAT_HI          11
`define DMVC_CAT_LO          4
`define DMVC_BIT_CRST        0
`define DMVC_FSR_W           5
`define DMVC_FSR_VCATCH      3
`define DMVC_NCAT            8
`define DMVC_CAT_SF          7
`define DMVC_PROT_PRIV       0
`define DMVC_PROT_NS         1
`define DMVC_ZERO32          32'h0000_0000
`define DMVC_ZERO_CAT        8'h00
`define DMVC_ZERO_FSR        5'h00
`endif

// file: core/dmvc_top.v
// Debug monitor control, vector catch enables and debug fault status, APB slave.
`include "dmvc_consts.vh"
`timescale 1ns/100ps
`default_nettype none

// Interface overview.
// The APB side answers every access after one wait state, so a transfer
// spends two cycles in its access phase. Read data, pready and pslverr all
// come from flip-flops, which costs that wait state but keeps the read
// mux out of the bus return path.
// The core side sees registered levels and one-cycle pulses, one cycle after a direct input,
// two after one held first in pend_r, men_r, step_r or the target status bit, so the core may sample them on any enabled edge.
// Two resets reach the block. The cold reset is asynchronous and clears
// every flip-flop. The warm reset is a synchronous level that only clears
// the monitor fields; catch enables and fault flags survive it so that a
// debugger can catch the reset itself.
// The clock enable freezes every flip-flop, the bus answer included, so a
// master must not expect pready while it is held low.

module dmvc_top
(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [2:0]  pprot,
  input  wire        dbg_access,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        warm_rst,
  input  wire        halting_debug_enabled,
  input  wire        halt_permission_check,
  input  wire        secure_debug_permitted,
  input  wire        secure_monitor_permission_check,
  input  wire        core_halted,
  input  wire        mon_active,
  input  wire        mon_hw_pend,
  input  wire        mon_taken,
  input  wire [7:0]  fault_evt,
  input  wire        fault_tgt_secure,
  input  wire [4:0]  dbg_evt,
  output reg         monitor_pending_ctl_req,
  output reg         mon_enabled,
  output reg         monitor_single_step_en,
  output reg         mon_secure_tgt,
  output reg         catch_halt_req,
  output reg         reset_catch_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Decode is used for both the answer and the write strobe.
  function [2:0] dmvc_decode;
    input [31:0] addr;
    begin
      case (addr)
        `DMVC_ADDR_FSR:    dmvc_decode = `DMVC_SEL_FSR;
        `DMVC_ADDR_FSR_NS: dmvc_decode = `DMVC_SEL_FSR_NS;
        `DMVC_ADDR_EMC:    dmvc_decode = `DMVC_SEL_EMC;
        `DMVC_ADDR_EMC_NS: dmvc_decode = `DMVC_SEL_EMC_NS;
        // Unmatched addresses fall to the none code, which the refusal logic
        // turns into a bus error rather than a silent zero.
        default:           dmvc_decode = `DMVC_SEL_NONE;
      endcase
    end
  endfunction

  // The Non-secure aliases of both registers share the decode with the primary
  // addresses. Only the view of the requester differs: a Non-secure caller
  // or the debugger reads zero and cannot write, without an error, which
  // mirrors the treatment of the other reserved alias locations.
  // Refusal is checked first so that an unprivileged alias access still
  // gets its bus error.
  wire [2:0] sel_w;
  wire       priv_w;
  wire       ns_view_w;
  wire       alias_w;
  wire       refuse_w;
  wire       acc_w;
  wire       wr_ok_w;
  wire       emc_wr_w;
  wire       fsr_wr_w;

  assign sel_w     = dmvc_decode(paddr);
  assign priv_w    = pprot[`DMVC_PROT_PRIV];
  assign ns_view_w = pprot[`DMVC_PROT_NS] | dbg_access;
  assign alias_w   = (sel_w == `DMVC_SEL_FSR_NS) | (sel_w == `DMVC_SEL_EMC_NS);
  // Unprivileged or unmapped accesses get an error answer.
  assign refuse_w  = ~priv_w | (sel_w == `DMVC_SEL_NONE);
  assign acc_w     = psel & penable & pready;
  // Alias writes from the Non-secure view or the debugger are dropped.
  assign wr_ok_w   = acc_w & pwrite & ~refuse_w & ~(alias_w & ns_view_w);
  assign emc_wr_w  = wr_ok_w & ((sel_w == `DMVC_SEL_EMC) | (sel_w == `DMVC_SEL_EMC_NS));
  assign fsr_wr_w  = wr_ok_w & ((sel_w == `DMVC_SEL_FSR) | (sel_w == `DMVC_SEL_FSR_NS));

  ////////////////////////////////////////////////////////////////////////////
  // Control and status state.

  // Only the fields that are implemented hold flip-flops. Reserved control
  // bits and the upper fault status bits are constants in the read path, so
  // a write to them can change nothing.
  // The catch enables are kept as one vector in fault_evt order, which lets
  // the gate and the fire logic be a single bitwise expression.
  reg                   secure_monitor_target_status_r;
  reg                   sema_r;
  reg                   step_r;
  reg                   pend_r;
  reg                   men_r;
  reg [`DMVC_NCAT-1:0]  cat_r;
  reg                   crst_r;
  reg [`DMVC_FSR_W-1:0] fsr_r;

  wire [`DMVC_NCAT-1:0] cat_gate_w;
  wire [`DMVC_NCAT-1:0] cat_fire_w;
  wire                  halt_ok_w;
  wire                  rst_catch_w;
  wire [31:0]           emc_rd_w;
  wire [31:0]           fsr_rd_w;

  // Common gate: debug enabled and halting permitted.
  assign halt_ok_w = halting_debug_enabled & halt_permission_check;

  // Per-catch gating; the SecureFault catch always needs secure debug,
  // the others only when the fault targets Secure state.
  genvar gi;
  generate
    for (gi = 0; gi < `DMVC_NCAT; gi = gi + 1)
    begin : g_cat
      if (gi == `DMVC_CAT_SF)
      begin : g_sf
        assign cat_gate_w[gi] = halt_ok_w & secure_debug_permitted;
      end
      else
      begin : g_oth
        // Order: hard, entry, bus, state, check, coproc, memmanage.
        assign cat_gate_w[gi] = halt_ok_w &
                                (secure_debug_permitted | ~fault_tgt_secure);
      end
    end
  endgenerate

  // Bits 6..0 cover hard/entry/bus/state/check/coproc/memmanage faults.
  assign cat_fire_w  = fault_evt & cat_r &
                       cat_gate_w;
  // Reset catch ignores secure permission, even into Secure state.
  assign rst_catch_w = warm_rst & crst_r & halt_ok_w;

  // Reserved fields are built as constant zeros.
  assign emc_rd_w = {11'h000, secure_monitor_target_status_r, sema_r, step_r, pend_r, men_r, 4'h0,
                     cat_r, 3'h0, crst_r};
  assign fsr_rd_w = {27'h0000000, fsr_r};

  ////////////////////////////////////////////////////////////////////////////
  // Monitor control bits, cleared by both resets.

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sema_r <= 1'b0;
      step_r <= 1'b0;
      men_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (warm_rst)
      begin
        sema_r <= 1'b0;
        step_r <= 1'b0;
        men_r  <= 1'b0;
      end
      else if (emc_wr_w)
      begin
        // Semaphore has no effect on anything else in the block.
        sema_r <= pwdata[`DMVC_BIT_SEMA];
        // Changing step at low priority is software's own hazard.
        step_r <= pwdata[`DMVC_BIT_STEP];
        men_r  <= pwdata[`DMVC_BIT_MEN];
      end
    end
  end

  // A write of one and a write of zero both act, so software can withdraw a
  // pending monitor request it made itself. The enable bit is not looked at
  // here: a request may wait, pended, until the monitor is enabled.
  // Pend: hardware set wins over a software clear and over acceptance.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pend_r <= 1'b0;
    else if (ce)
    begin
      if (warm_rst)
        pend_r <= 1'b0;
      else if (mon_hw_pend)
        pend_r <= 1'b1;
      else if (emc_wr_w)
        pend_r <= pwdata[`DMVC_BIT_PEND];
      else if (mon_taken)
        pend_r <= 1'b0;
    end
  end

  // While the monitor is pended or running the target must not move under
  // the handler's feet, so the last value is held until both clear.
  // Secure target status follows the permission only while idle.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      secure_monitor_target_status_r <= 1'b0;
    else if (ce)
    begin
      if (~pend_r & ~mon_active)
        secure_monitor_target_status_r <= secure_monitor_permission_check;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Catch enables: only the asynchronous cold reset clears them.
  // Keeping these over a warm reset is what makes the reset catch work: the
  // enable written before the reset is still set when the reset arrives.

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cat_r  <= `DMVC_ZERO_CAT;
      crst_r <= 1'b0;
    end
    else if (ce)
    begin
      // Warm reset deliberately leaves these alone.
      if (emc_wr_w)
      begin
        cat_r  <= pwdata[`DMVC_CAT_HI:`DMVC_CAT_LO];
        crst_r <= pwdata[`DMVC_BIT_CRST];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug fault status flags: sticky, set wins over write-one-to-clear.

  // A flag set and its clear in the same cycle leave the flag set, so an
  // event that lands during a clearing write is never lost.
  wire [`DMVC_FSR_W-1:0] fsr_set_w;
  wire [`DMVC_FSR_W-1:0] fsr_clr_w;

  generate
    for (gi = 0; gi < `DMVC_FSR_W; gi = gi + 1)
    begin : g_fsr
      if (gi == `DMVC_FSR_VCATCH)
      begin : g_vc
        // Our own catches count as vector catch events too.
        assign fsr_set_w[gi] = dbg_evt[gi] | (|cat_fire_w) | rst_catch_w;
      end
      else
      begin : g_ev
        assign fsr_set_w[gi] = dbg_evt[gi];
      end
      assign fsr_clr_w[gi] = fsr_wr_w & pwdata[gi];
    end
  endgenerate

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fsr_r <= `DMVC_ZERO_FSR;
    else if (ce)
      fsr_r <= fsr_set_w | (fsr_r & ~fsr_clr_w);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core, all registered.
  // Every core-facing signal is registered, so each answer is one cycle after a direct input
  // and two after one held first in pend_r, men_r, step_r or the target status bit; the core model is written to that latency.

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      monitor_pending_ctl_req    <= 1'b0;
      mon_enabled     <= 1'b0;
      monitor_single_step_en     <= 1'b0;
      mon_secure_tgt  <= 1'b0;
      catch_halt_req  <= 1'b0;
      reset_catch_evt <= 1'b0;
    end
    else if (ce)
    begin
      // Pending is offered to arbitration regardless of the enable.
      monitor_pending_ctl_req    <= pend_r;
      // A halted core ignores the monitor enable.
      mon_enabled     <= men_r & ~core_halted;
      monitor_single_step_en     <= step_r & ~core_halted;
      mon_secure_tgt  <= secure_monitor_target_status_r;
      catch_halt_req  <= |cat_fire_w;
      reset_catch_evt <= rst_catch_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, so read data is registered on the same edge as pready.
  // The answer is generated on the first access-phase edge and stands for
  // one cycle. The write itself is applied on the following edge, when the
  // master samples pready, so a master that stretches its request by a cycle
  // still sees exactly one write.
  // Read data stays in prdata until the next answer replaces it.

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `DMVC_ZERO32;
    end
    else if (ce)
    begin
      if (psel & penable & ~pready)
      begin
        pready  <= 1'b1;
        // Narrow accesses are not detectable on this bus; all are words.
        pslverr <= refuse_w;
        if (pwrite | refuse_w | (alias_w & ns_view_w))
          prdata <= `DMVC_ZERO32;
        else if ((sel_w == `DMVC_SEL_FSR) | (sel_w == `DMVC_SEL_FSR_NS))
          prdata <= fsr_rd_w;
        else
          prdata <= emc_rd_w;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: sim/debug_monitor_vector_catch_ctrl_test.sv
// Directed bench for the debug monitor and catch control block.
`include "dmvc_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module debug_monitor_vector_catch_ctrl_test;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dbg_access = 0, warm_rst = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdv;
  logic [2:0] pprot = 3'h1;
  logic pready, pslverr, erv, hde = 1, hpc = 1, sdp = 1, smp = 0, halted = 0, tgt_s = 0;
  logic [7:0] fault_req = 0, fault_evt;
  logic [4:0] dbg_evt = 0;
  logic mon_taken, mon_active, pend, men, stp, stgt, chr, rce;
  int error_cnt = 0, comparisons = 0;
  dmvc_top DUT (.clk_sys, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pprot,
    .dbg_access, .prdata, .pready, .pslverr, .warm_rst, .halting_debug_enabled(hde),
    .halt_permission_check(hpc), .secure_debug_permitted(sdp),
    .secure_monitor_permission_check(smp), .core_halted(halted), .mon_active,
    .mon_hw_pend(1'b0), .mon_taken, .fault_evt, .fault_tgt_secure(tgt_s), .dbg_evt,
    .monitor_pending_ctl_req(pend), .mon_enabled(men), .monitor_single_step_en(stp), .mon_secure_tgt(stgt),
    .catch_halt_req(chr), .reset_catch_evt(rce));
  dmvc_core_model u_core (.clk_sys, .rst, .fault_req, .monitor_pending_ctl_req(pend), .mon_enabled(men),
    .fault_evt, .mon_taken, .mon_active);
  initial forever #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Whole-word APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [2:0] p);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pprot <= p;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [2:0] p, input logic [31:0] e,
                    input logic ee);
    apb(0, a, 0, p);
    chk("prdata", e, rdv);
    chk("pslverr", {31'h0, ee}, {31'h0, erv});
  endtask
  // A one-cycle fault pulse reaches the block a cycle later; the halt request follows.
  task automatic fire(input int i, input logic e);
    @(posedge clk_sys); fault_req <= 8'h01 << i;
    @(posedge clk_sys); fault_req <= 8'h00;
    @(posedge clk_sys); #1;
    chk("catch_halt_req", {31'h0, e}, {31'h0, chr});
  endtask
  task automatic complete_run;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    rd(`DMVC_ADDR_EMC, 3'h1, 32'h0, 0);
    apb(1, `DMVC_ADDR_EMC, 32'hfffe_ffff, 3'h1);
    rd(`DMVC_ADDR_EMC, 3'h1, 32'h000e_0ff1, 0);
    chk("monitor_pending_ctl_req", 1, pend);
    chk("monitor_single_step_en", 1, stp);
    apb(1, `DMVC_ADDR_EMC, 32'h0, 3'h0);
    rd(`DMVC_ADDR_EMC, 3'h1, 32'h000e_0ff1, 0);
    rd(32'he000_ed34, 3'h1, 32'h0, 1);
    rd(`DMVC_ADDR_EMC_NS, 3'h3, 32'h0, 0);
    dbg_access <= 1;
    rd(`DMVC_ADDR_EMC_NS, 3'h1, 32'h0, 0);
    dbg_access <= 0;
    rd(`DMVC_ADDR_EMC_NS, 3'h1, 32'h000e_0ff1, 0);
    @(posedge clk_sys); warm_rst <= 1;
    @(posedge clk_sys); warm_rst <= 0; #1;
    chk("reset_catch_evt", 1, rce);
    rd(`DMVC_ADDR_EMC, 3'h1, 32'h0000_0ff1, 0);
    apb(1, `DMVC_ADDR_FSR, 32'h1f, 3'h1);
    rd(`DMVC_ADDR_FSR, 3'h0, 32'h0, 1);
    for (int i = 0; i < 8; i++) fire(i, 1);
    hde <= 0;
    fire(6, 0);
    hde <= 1; tgt_s <= 1; sdp <= 0;
    fire(6, 0);
    fire(7, 0);
    sdp <= 1;
    fire(7, 1);
    rd(`DMVC_ADDR_FSR, 3'h1, 32'h8, 0);
    @(posedge clk_sys); dbg_evt <= 5'h17;
    @(posedge clk_sys); dbg_evt <= 5'h00;
    rd(`DMVC_ADDR_FSR, 3'h1, 32'h1f, 0);
    apb(1, `DMVC_ADDR_FSR, 32'h1f, 3'h1);
    rd(`DMVC_ADDR_FSR, 3'h1, 32'h0, 0);
    halted <= 1;
    apb(1, `DMVC_ADDR_EMC, 32'h0003_0ff1, 3'h1);
    chk("mon_enabled", 0, men);
    halted <= 0; smp <= 1;
    repeat (12) @(posedge clk_sys);
    rd(`DMVC_ADDR_EMC, 3'h1, 32'h0011_0ff1, 0);
    chk("mon_secure_tgt", 1, stgt);
    complete_run();
  end
  // Guards against a stalled handshake.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire

// file: sim/dmvc_core_model.sv
// Behavioural model of the core exception logic facing the block.
`timescale 1ns/100ps
`default_nettype none
module dmvc_core_model
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] fault_req,
  input wire logic       monitor_pending_ctl_req,
  input wire logic       mon_enabled,
  output var logic [7:0] fault_evt,
  output var logic       mon_taken,
  output var logic       mon_active
);
  logic [2:0] act_cnt_r;
  // The arbiter takes a pending monitor only when enabled and idle, then runs it a while.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fault_evt <= 8'h00;
      mon_taken <= 1'b0;
      act_cnt_r <= 3'h0;
    end
    else
    begin
      fault_evt <= fault_req;
      mon_taken <= monitor_pending_ctl_req && mon_enabled && !mon_taken && !mon_active;
      act_cnt_r <= mon_taken ? 3'h4 : (act_cnt_r != 3'h0 ? act_cnt_r - 3'h1 : 3'h0);
    end
  end
  assign mon_active = (act_cnt_r != 3'h0);
endmodule
`default_nettype wire

// file: sim/dmvc_props.sv
// Concurrent checks on the ports of the debug monitor and catch control block.
`timescale 1ns/100ps
`default_nettype none
module dmvc_props
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        warm_rst,
  input wire logic        halting_debug_enabled,
  input wire logic        halt_permission_check,
  input wire logic        core_halted,
  input wire logic        mon_active,
  input wire logic        catch_halt_req,
  input wire logic        reset_catch_evt,
  input wire logic        mon_enabled,
  input wire logic        monitor_single_step_en,
  input wire logic        mon_secure_tgt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // The slave answers after exactly one wait state, as a single-cycle pulse.
  a_ready_one_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late");
  a_ready_single_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_unpriv_refused: assert property (psel && penable && !pready && ce && !pprot[0]
    |=> pslverr)
    else $error("unprivileged access served");
  a_error_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_catch_gated: assert property (catch_halt_req
    |-> $past(halting_debug_enabled && halt_permission_check))
    else $error("catch fired while gated");
  a_catch_off_quiet: assert property (!halting_debug_enabled |=> !catch_halt_req)
    else $error("catch fired without debug");
  a_reset_catch_cause: assert property (reset_catch_evt
    |-> $past(warm_rst && halting_debug_enabled && halt_permission_check))
    else $error("reset catch without cause");
  a_monitor_halted: assert property (core_halted |=> !mon_enabled && !monitor_single_step_en)
    else $error("monitor live while halted");
  a_target_held: assert property (mon_active [*2] |=> $stable(mon_secure_tgt))
    else $error("target status moved while active");
  // Main scenarios are expected to reach these states.
  c_catch: cover property (catch_halt_req);
  c_reset_catch: cover property (reset_catch_evt);
  c_refused: cover property (pready && pslverr);
endmodule
bind dmvc_top dmvc_props u_props (.clk_sys, .rst, .ce, .psel, .penable, .pprot, .prdata, .pready,
  .pslverr, .warm_rst, .halting_debug_enabled, .halt_permission_check, .core_halted, .mon_active,
  .catch_halt_req, .reset_catch_evt, .mon_enabled, .monitor_single_step_en, .mon_secure_tgt);
`default_nettype wire
